// [design/byte_fifo.sv]
// Purpose: sixteen-entry byte FIFO with valid/ready on both sides
// Assumes: same clock as the bus; flush empties it in one cycle
// Notes: storage is flip-flops indexed by pointers
`timescale 1ns/1ps
module byte_fifo (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic flush_i,
    input wire logic push_valid_i,
    input wire logic [7:0] push_data_i,
    output logic push_ready_o,
    output logic pop_valid_o,
    output logic [7:0] pop_data_o,
    input wire logic pop_ready_i
);
    typedef struct packed {
        logic [shadow_data_pkg::FIFO_DEPTH-1:0][7:0] mem;
        logic [shadow_data_pkg::PTR_W-1:0] wr;
        logic [shadow_data_pkg::PTR_W-1:0] rd;
        logic [shadow_data_pkg::CNT_W-1:0] cnt;
    } fifo_state_t;

    fifo_state_t state_r;
    fifo_state_t state_nxt;
    logic do_push;
    logic do_pop;

    // ======================================================================
    // flags: full refuses pushes, nothing is overwritten
    assign push_ready_o = (state_r.cnt != shadow_data_pkg::FIFO_FULL_CNT);
    assign pop_valid_o = (state_r.cnt != '0);
    assign pop_data_o = state_r.mem[state_r.rd];
    assign do_push = push_valid_i & push_ready_o;
    assign do_pop = pop_valid_o & pop_ready_i;

    // ======================================================================
    // pointer and count update
    always_comb begin
        state_nxt = state_r;
        if (flush_i) begin
            state_nxt.wr = '0;
            state_nxt.rd = '0;
            state_nxt.cnt = '0;
        end else begin
            if (do_push) begin
                state_nxt.mem[state_r.wr] = push_data_i;
                state_nxt.wr = state_r.wr + 4'h1;
            end
            if (do_pop) begin
                state_nxt.rd = state_r.rd + 4'h1;
            end
            if (do_push && !do_pop) begin
                state_nxt.cnt = state_r.cnt + 5'h01;
            end else if (!do_push && do_pop) begin
                state_nxt.cnt = state_r.cnt - 5'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule // byte_fifo

// [design/shadow_data_pkg.sv]
// Purpose: constants for the aliased receive/transmit data window of a UART
// Assumes: 32-bit APB, byte-wide character data, one 25 MHz clock
// Notes: offsets are byte addresses
package shadow_data_pkg;

    // ======================================================================
    // data and buffer geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // ======================================================================
    // address map
    localparam logic [31:0] SHADOW_RX_TX_DATA_5_ADDR = 32'h50001144;
    localparam logic [31:0] SHADOW_BASE_ADDR =
        SHADOW_RX_TX_DATA_5_ADDR - 32'h00000014;
    localparam logic [31:0] SHADOW_LAST_ADDR =
        SHADOW_BASE_ADDR + 32'h0000003c;
    localparam logic [31:0] CTRL_ADDR = 32'h50001170;
    localparam logic [31:0] LINE_STATUS_ADDR = 32'h50001174;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h50001178;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000117c;

    // ======================================================================
    // field positions
    localparam int unsigned CTRL_FIFO_EN_BIT = 0;
    localparam int unsigned CTRL_IR_MODE_BIT = 1;
    localparam int unsigned LSR_DATA_READY_BIT = 0;
    localparam int unsigned LSR_OVERRUN_BIT = 1;
    localparam int unsigned LSR_THR_EMPTY_BIT = 5;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RX_BIT = 0;
    localparam int unsigned IRQ_OVERRUN_BIT = 1;
    localparam int unsigned IRQ_THR_EMPTY_BIT = 2;

    // ======================================================================
    // reset values
    localparam logic CTRL_FIFO_EN_RST = 1'b0;
    localparam logic CTRL_IR_MODE_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

endpackage

// [design/shadow_data_port.sv]
// Purpose: APB data window onto the receive buffer and transmit holding
// Assumes: byte framing, baud and infrared coding live outside this block
// Notes: zero-wait APB slave; unmapped addresses answer with pslverr
`timescale 1ns/1ps
module shadow_data_port (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // received characters from the serial and infrared decoders
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] ir_rx_data_i,
    input wire logic ir_rx_valid_i,
    // characters to the serial and infrared transmitters
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [7:0] ir_tx_data_o,
    output logic ir_tx_valid_o,
    input wire logic ir_tx_ready_i,
    // status toward the rest of the uart
    output logic data_ready_flag_o,
    output logic tx_holding_empty_flag_o,
    output logic fifo_enable_o,
    output logic overrun_o,
    output logic irq_o
);
    typedef struct packed {
        logic fifo_en;
        logic ir_mode;
        logic [shadow_data_pkg::IRQ_W-1:0] irq_mask;
        logic [shadow_data_pkg::IRQ_W-1:0] irq_stat;
        logic [7:0] rx_buffer_reg;
        logic rx_buffer_vld;
        logic [7:0] tx_holding_reg;
        logic tx_holding_vld;
        logic [31:0] prdata;
        logic rd_pop_ok;
        logic overrun_sticky;
        logic overrun_pulse;
        logic thr_empty_prev;
    } port_state_t;

    port_state_t state_r;
    port_state_t state_nxt;

    // decode
    logic setup_ph;
    logic access_ph;
    logic shadow_hit;
    logic ctrl_hit;
    logic lsr_hit;
    logic istat_hit;
    logic imask_hit;
    logic mapped;
    logic wr_low;
    logic shadow_wr;
    logic shadow_rd_done;
    logic ctrl_wr;
    // receive path
    logic [7:0] rx_in_data;
    logic rx_in_vld;
    logic rxf_ready;
    logic rxf_valid;
    logic [7:0] rxf_data;
    logic rxf_pop;
    logic data_ready;
    logic [7:0] rx_head;
    logic rx_overrun;
    // transmit path
    logic txf_push;
    logic txf_ready;
    logic txf_valid;
    logic [7:0] txf_data;
    logic tx_out_ready;
    logic tx_out_valid;
    logic [7:0] tx_head;
    logic tx_taken;
    logic thr_empty;
    // misc
    logic flush;
    logic [shadow_data_pkg::IRQ_W-1:0] irq_set;
    logic [shadow_data_pkg::IRQ_W-1:0] irq_clr;
    logic [31:0] rd_mux;

    // ======================================================================
    // apb phase and address decode
    assign setup_ph = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;

    // sixteen aligned words share one data port
    always_comb begin
        shadow_hit = 1'b0;
        ctrl_hit = 1'b0;
        lsr_hit = 1'b0;
        istat_hit = 1'b0;
        imask_hit = 1'b0;
        if ((paddr_i >= shadow_data_pkg::SHADOW_BASE_ADDR) &&
            (paddr_i <= shadow_data_pkg::SHADOW_LAST_ADDR) &&
            (paddr_i[1:0] == 2'h0)) begin
            shadow_hit = 1'b1;
        end else if (paddr_i == shadow_data_pkg::CTRL_ADDR) begin
            ctrl_hit = 1'b1;
        end else if (paddr_i == shadow_data_pkg::LINE_STATUS_ADDR) begin
            lsr_hit = 1'b1;
        end else if (paddr_i == shadow_data_pkg::IRQ_STATUS_ADDR) begin
            istat_hit = 1'b1;
        end else if (paddr_i == shadow_data_pkg::IRQ_MASK_ADDR) begin
            imask_hit = 1'b1;
        end
    end

    assign mapped = shadow_hit | ctrl_hit | lsr_hit | istat_hit | imask_hit;
    assign pready_o = 1'b1;
    assign pslverr_o = access_ph & ~mapped;
    assign prdata_o = state_r.prdata;

    // only byte lane 0 carries data; upper lanes are ignored
    assign wr_low = access_ph & pwrite_i & pstrb_i[0];
    assign shadow_wr = wr_low & shadow_hit;
    assign ctrl_wr = wr_low & ctrl_hit;
    assign shadow_rd_done = access_ph & ~pwrite_i & shadow_hit &
                            state_r.rd_pop_ok;

    // ======================================================================
    // changing the fifo mode empties both directions
    assign flush = ctrl_wr &
        (pwdata_i[shadow_data_pkg::CTRL_FIFO_EN_BIT] != state_r.fifo_en);

    // ======================================================================
    // receive side: pick the decoder for the active mode
    assign rx_in_data = state_r.ir_mode ? ir_rx_data_i : rx_data_i;
    assign rx_in_vld = state_r.ir_mode ? ir_rx_valid_i : rx_valid_i;

    // receive fifo pops only on a completed read of a valid byte
    assign rxf_pop = shadow_rd_done & state_r.fifo_en;

    byte_fifo rx_fifo (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .flush_i(flush),
        .push_valid_i(rx_in_vld & state_r.fifo_en),
        .push_data_i(rx_in_data),
        .push_ready_o(rxf_ready),
        .pop_valid_o(rxf_valid),
        .pop_data_o(rxf_data),
        .pop_ready_i(rxf_pop)
    );

    assign data_ready = state_r.fifo_en ? rxf_valid : state_r.rx_buffer_vld;
    assign rx_head = state_r.fifo_en ? rxf_data : state_r.rx_buffer_reg;

    // overrun: full fifo drops the byte, single buffer is replaced
    always_comb begin
        rx_overrun = 1'b0;
        if (rx_in_vld && !flush) begin
            if (state_r.fifo_en) begin
                rx_overrun = ~rxf_ready;
            end else begin
                rx_overrun = state_r.rx_buffer_vld & ~shadow_rd_done;
            end
        end
    end

    // ======================================================================
    // transmit side: full fifo drops the write silently
    assign txf_push = shadow_wr & state_r.fifo_en & ~flush;

    assign tx_out_ready = state_r.ir_mode ? ir_tx_ready_i : tx_ready_i;
    assign tx_out_valid = state_r.fifo_en ? txf_valid : state_r.tx_holding_vld;
    assign tx_head = state_r.fifo_en ? txf_data : state_r.tx_holding_reg;
    assign tx_taken = tx_out_valid & tx_out_ready;

    byte_fifo tx_fifo (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .flush_i(flush),
        .push_valid_i(txf_push),
        .push_data_i(pwdata_i[7:0]),
        .push_ready_o(txf_ready),
        .pop_valid_o(txf_valid),
        .pop_data_o(txf_data),
        .pop_ready_i(tx_out_ready & state_r.fifo_en)
    );

    // holding-empty follows the fifo or the single holding register
    assign thr_empty = state_r.fifo_en ? ~txf_valid : ~state_r.tx_holding_vld;

    // only the active transmitter sees a valid character
    assign tx_data_o = tx_head;
    assign ir_tx_data_o = tx_head;
    assign tx_valid_o = tx_out_valid & ~state_r.ir_mode;
    assign ir_tx_valid_o = tx_out_valid & state_r.ir_mode;

    // ======================================================================
    // interrupt events and write-one-to-clear
    always_comb begin
        irq_set = '0;
        irq_set[shadow_data_pkg::IRQ_RX_BIT] = rx_in_vld & ~rx_overrun;
        irq_set[shadow_data_pkg::IRQ_OVERRUN_BIT] = rx_overrun;
        irq_set[shadow_data_pkg::IRQ_THR_EMPTY_BIT] =
            thr_empty & ~state_r.thr_empty_prev;
        irq_clr = '0;
        if (wr_low && istat_hit) begin
            irq_clr = pwdata_i[shadow_data_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(state_r.irq_stat & state_r.irq_mask);

    // ======================================================================
    // read data mux; the data port shows only the low byte
    always_comb begin
        rd_mux = '0;
        if (shadow_hit) begin
            rd_mux[7:0] = rx_head;
        end else if (ctrl_hit) begin
            rd_mux[shadow_data_pkg::CTRL_FIFO_EN_BIT] = state_r.fifo_en;
            rd_mux[shadow_data_pkg::CTRL_IR_MODE_BIT] = state_r.ir_mode;
        end else if (lsr_hit) begin
            rd_mux[shadow_data_pkg::LSR_DATA_READY_BIT] = data_ready;
            rd_mux[shadow_data_pkg::LSR_OVERRUN_BIT] = state_r.overrun_sticky;
            rd_mux[shadow_data_pkg::LSR_THR_EMPTY_BIT] = thr_empty;
        end else if (istat_hit) begin
            rd_mux[shadow_data_pkg::IRQ_W-1:0] = state_r.irq_stat;
        end else if (imask_hit) begin
            rd_mux[shadow_data_pkg::IRQ_W-1:0] = state_r.irq_mask;
        end
    end

    // ======================================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.overrun_pulse = rx_overrun;
        state_nxt.thr_empty_prev = thr_empty;

        // read data and pop permission are fixed in the setup cycle
        if (setup_ph) begin
            state_nxt.prdata = pwrite_i ? 32'h00000000 : rd_mux;
            state_nxt.rd_pop_ok = shadow_hit & ~pwrite_i & data_ready;
        end else if (access_ph) begin
            state_nxt.rd_pop_ok = 1'b0;
        end

        // configuration
        if (ctrl_wr) begin
            state_nxt.fifo_en = pwdata_i[shadow_data_pkg::CTRL_FIFO_EN_BIT];
            state_nxt.ir_mode = pwdata_i[shadow_data_pkg::CTRL_IR_MODE_BIT];
        end
        if (wr_low && imask_hit) begin
            state_nxt.irq_mask = pwdata_i[shadow_data_pkg::IRQ_W-1:0];
        end

        // sticky status: a new event wins over the clear
        state_nxt.irq_stat = (state_r.irq_stat & ~irq_clr) | irq_set;
        if (access_ph && !pwrite_i && lsr_hit) begin
            state_nxt.overrun_sticky = 1'b0;
        end
        if (rx_overrun) begin
            state_nxt.overrun_sticky = 1'b1;
        end

        // single receive buffer: read empties it, new byte replaces it
        if (flush) begin
            state_nxt.rx_buffer_vld = 1'b0;
        end else if (!state_r.fifo_en) begin
            if (shadow_rd_done) begin
                state_nxt.rx_buffer_vld = 1'b0;
            end
            if (rx_in_vld) begin
                state_nxt.rx_buffer_reg = rx_in_data;
                state_nxt.rx_buffer_vld = 1'b1;
            end
        end

        // single holding register: a write fills or overwrites it
        if (flush) begin
            state_nxt.tx_holding_vld = 1'b0;
        end else if (!state_r.fifo_en) begin
            if (tx_taken) begin
                state_nxt.tx_holding_vld = 1'b0;
            end
            if (shadow_wr) begin
                state_nxt.tx_holding_reg = pwdata_i[7:0];
                state_nxt.tx_holding_vld = 1'b1;
            end
        end
    end

    // ======================================================================
    // status outputs
    assign data_ready_flag_o = data_ready;
    assign tx_holding_empty_flag_o = thr_empty;
    assign fifo_enable_o = state_r.fifo_en;
    assign overrun_o = state_r.overrun_pulse;

    // ======================================================================
    // state register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= '0;
            state_r.fifo_en <= shadow_data_pkg::CTRL_FIFO_EN_RST;
            state_r.ir_mode <= shadow_data_pkg::CTRL_IR_MODE_RST;
            state_r.irq_mask <= shadow_data_pkg::IRQ_MASK_RST;
            state_r.rx_buffer_reg <= shadow_data_pkg::DATA_RST;
            state_r.tx_holding_reg <= shadow_data_pkg::DATA_RST;
            state_r.thr_empty_prev <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule // shadow_data_port

// [tb/serial_peer_model.sv]
// Purpose: serial or infrared far-side peer
// Assumes: bytes on the uart clock, no framing
// Notes: idle receive lines show the inverse of the last byte sent
`timescale 1ns/1ps
module serial_peer_model (
    input wire logic clk_sys_i,
    input wire logic stall_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] ir_tx_data_i,
    input wire logic ir_tx_valid_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic [7:0] ir_rx_data_o,
    output logic ir_rx_valid_o,
    output logic tx_ready_o,
    output logic ir_tx_ready_o
);
    logic [8:0] got[$];
    // ======================================================================
    // idle receive lines at time zero
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        ir_rx_data_o = 8'h00;
        ir_rx_valid_o = 1'b0;
    end
    // ready unless stalled
    assign tx_ready_o = !stall_i;
    assign ir_tx_ready_o = !stall_i;
    // log each byte with its path
    always @(posedge clk_sys_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got.push_back({1'b0, tx_data_i});
        end
        if (ir_tx_valid_i && ir_tx_ready_o) begin
            got.push_back({1'b1, ir_tx_data_i});
        end
    end
    // one byte as a one-cycle pulse on one path
    task automatic send(input logic [7:0] b, input logic ir);
        @(posedge clk_sys_i);
        if (ir) begin
            ir_rx_data_o <= b;
            ir_rx_valid_o <= 1'b1;
        end else begin
            rx_data_o <= b;
            rx_valid_o <= 1'b1;
        end
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        ir_rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
        ir_rx_data_o <= ~b;
    endtask
endmodule // serial_peer_model

// [tb/shadow_data_port_assertions.sv]
// Purpose: port checks for the data window
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound by the bind at the foot
`timescale 1ns/1ps
module shadow_data_port_checker (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic rx_valid_i,
    input wire logic ir_rx_valid_i,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic ir_tx_valid_o,
    input wire logic data_ready_flag_o,
    input wire logic tx_holding_empty_flag_o,
    input wire logic fifo_enable_o,
    input wire logic overrun_o
);
    logic data_hit;
    logic unmapped;
    logic any_acc;
    logic rx_any;
    // ======================================================================
    // decode and event helpers
    assign data_hit = (paddr_i >= shadow_data_pkg::SHADOW_BASE_ADDR) &&
        (paddr_i <= shadow_data_pkg::SHADOW_LAST_ADDR) && (paddr_i[1:0] == 2'h0);
    assign unmapped = (paddr_i < shadow_data_pkg::SHADOW_BASE_ADDR) ||
        (paddr_i > shadow_data_pkg::IRQ_MASK_ADDR) || (paddr_i[1:0] != 2'h0);
    assign any_acc = psel_i && penable_i;
    assign rx_any = rx_valid_i || ir_rx_valid_i;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_data_wr;
        any_acc && pwrite_i && pstrb_i[0] && data_hit;
    endsequence
    sequence s_idle_empty;
        !fifo_enable_o && tx_holding_empty_flag_o;
    endsequence
    // ======================================================================
    // bus answer
    a_ready_const: assert property (pready_o)
        else $error("pready not high");
    a_slverr_map: assert property (pslverr_o == (any_acc && unmapped))
        else $error("bad error response");
    a_high_bits: assert property (any_acc && !pwrite_i && data_hit |-> prdata_o[31:8] == 24'h0)
        else $error("upper data bits not zero");
    // ======================================================================
    // transmit side
    a_write_clears: assert property (s_data_wr ##0 s_idle_empty |=> !tx_holding_empty_flag_o)
        else $error("holding-empty still set");
    a_empty_novalid: assert property (tx_holding_empty_flag_o |-> !tx_valid_o && !ir_tx_valid_o)
        else $error("byte offered while holding empty");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i && !psel_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("stalled byte changed");
    // ======================================================================
    // receive side
    a_rx_ready: assert property (rx_any |=> data_ready_flag_o)
        else $error("data-ready not set");
    a_ready_cause: assert property ($rose(data_ready_flag_o) |-> $past(rx_any))
        else $error("data-ready without byte");
    a_overrun_buf: assert property (!fifo_enable_o && data_ready_flag_o && rx_any && !any_acc |-> ##[1:2] overrun_o)
        else $error("no overrun");
    a_overrun_cause: assert property (overrun_o |-> $past(rx_any) || $past(rx_any, 2))
        else $error("overrun without arrival");
endmodule // shadow_data_port_checker

bind shadow_data_port shadow_data_port_checker u_chk (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
    .ir_rx_valid_i(ir_rx_valid_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .ir_tx_valid_o(ir_tx_valid_o), .data_ready_flag_o(data_ready_flag_o),
    .tx_holding_empty_flag_o(tx_holding_empty_flag_o),
    .fifo_enable_o(fifo_enable_o), .overrun_o(overrun_o)
);

// [tb/shadow_data_port_tb.sv]
// Purpose: bench for the data window
// Assumes: zero-wait APB slave, peer model on the character side
// Notes: fifo-off, fifo-on and infrared paths each exercised
`timescale 1ns/1ps
module shadow_data_port_tb;
    localparam logic [31:0] BASE = shadow_data_pkg::SHADOW_BASE_ADDR;
    localparam logic [31:0] A5 = shadow_data_pkg::SHADOW_RX_TX_DATA_5_ADDR;
    localparam logic [31:0] CTRL = shadow_data_pkg::CTRL_ADDR;
    localparam logic [31:0] LINE_STATUS_REG = shadow_data_pkg::LINE_STATUS_ADDR;
    localparam logic [31:0] IST = shadow_data_pkg::IRQ_STATUS_ADDR;
    localparam logic [31:0] IMSK = shadow_data_pkg::IRQ_MASK_ADDR;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic stall = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, dr, tx_holding_empty_flag, fen, ovr;
    logic [7:0] rxd, irxd, txd, irtxd;
    logic rxv, irxv, txv, txr, irtxv, irtxr;
    logic [31:0] rv;
    logic ev;
    int fail_count = 0;
    int total_checks = 0;
    // ======================================================================
    // clock and instances
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    shadow_data_port dut (.clk_sys_i(clk_sys), .arst_n_i(arst_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rx_data_i(rxd), .rx_valid_i(rxv), .ir_rx_data_i(irxd),
        .ir_rx_valid_i(irxv), .tx_data_o(txd), .tx_valid_o(txv),
        .tx_ready_i(txr), .ir_tx_data_o(irtxd), .ir_tx_valid_o(irtxv),
        .ir_tx_ready_i(irtxr), .data_ready_flag_o(dr),
        .tx_holding_empty_flag_o(tx_holding_empty_flag), .fifo_enable_o(fen),
        .overrun_o(ovr), .irq_o(irq));
    serial_peer_model peer (.clk_sys_i(clk_sys), .stall_i(stall),
        .tx_data_i(txd), .tx_valid_i(txv), .ir_tx_data_i(irtxd),
        .ir_tx_valid_i(irtxv), .rx_data_o(rxd), .rx_valid_o(rxv),
        .ir_rx_data_o(irxd), .ir_rx_valid_o(irxv), .tx_ready_o(txr),
        .ir_tx_ready_o(irtxr));
    // ======================================================================
    // tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic rdc(input string what, input logic [31:0] a, exp);
        apb(1'b0, a, 32'h0);
        check(what, rv, exp);
    endtask
    task automatic wait_tx(input int k);
        int n;
        n = 0;
        while (peer.got.size() < k && n < 200) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 200) begin
            fail_count++;
            complete_run();
        end
    endtask
    // ======================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check("fifo_en", fen, 32'h0);
        rdc("ctrl", CTRL, 32'h0);
        rdc("mask", IMSK, 32'h0);
        rdc("lsr", LINE_STATUS_REG, 32'h20);
        apb(1'b0, 32'h50001180, 32'h0);
        check("slverr", ev, 32'h1);
        apb(1'b0, A5 + 32'h1, 32'h0);
        check("slverr_mis", ev, 32'h1);
        apb(1'b1, IMSK, 32'h1);
        peer.send(8'h5a, 1'b0);
        repeat (2) @(posedge clk_sys);
        check("irq_on", irq, 32'h1);
        rdc("rx", A5, 32'h5a);
        @(posedge clk_sys);
        check("dr_off", dr, 32'h0);
        apb(1'b1, IST, 32'h1);
        @(posedge clk_sys);
        check("irq_off", irq, 32'h0);
        peer.send(8'h11, 1'b0);
        peer.send(8'h22, 1'b0);
        repeat (3) @(posedge clk_sys);
        rdc("rx_ovr", BASE, 32'h22);
        rdc("lsr_ovr", LINE_STATUS_REG, 32'h22);
        rdc("lsr_clr", LINE_STATUS_REG, 32'h20);
        for (int i = 0; i < 16; i++) begin
            peer.send(8'h30 + 8'(i), 1'b0);
            repeat (2) @(posedge clk_sys);
            rdc("alias", BASE + 32'(4 * i), 32'h30 + 32'(i));
        end
        stall <= 1'b1;
        apb(1'b1, A5, 32'h0000ffa5);
        @(posedge clk_sys);
        check("tx_holding_empty_flag_clr", tx_holding_empty_flag, 32'h0);
        check("tx_low", txd, 32'ha5);
        apb(1'b1, A5, 32'h3c);
        @(posedge clk_sys);
        check("tx_over", txd, 32'h3c);
        stall <= 1'b0;
        wait_tx(1);
        repeat (4) @(posedge clk_sys);
        check("tx_cnt", 32'(peer.got.size()), 32'h1);
        check("tx_byte", peer.got[0], 32'h3c);
        peer.got.delete();
        apb(1'b1, CTRL, 32'h1);
        @(posedge clk_sys);
        check("fifo_on", fen, 32'h1);
        for (int i = 0; i < 17; i++) begin
            peer.send(8'h40 + 8'(i), 1'b0);
        end
        repeat (3) @(posedge clk_sys);
        rdc("lsr_full", LINE_STATUS_REG, 32'h23);
        for (int i = 0; i < 16; i++) begin
            rdc("rx_fifo", BASE + 32'(4 * i), 32'h40 + 32'(i));
        end
        @(posedge clk_sys);
        check("dr_empty", dr, 32'h0);
        stall <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            apb(1'b1, A5, 32'h60 + 32'(i));
        end
        check("tx_holding_empty_flag_fifo", tx_holding_empty_flag, 32'h0);
        stall <= 1'b0;
        wait_tx(16);
        repeat (4) @(posedge clk_sys);
        check("tx_fcnt", 32'(peer.got.size()), 32'h10);
        for (int i = 0; i < 16; i++) begin
            check("tx_fifo", peer.got[i], 32'h60 + 32'(i));
        end
        peer.got.delete();
        apb(1'b1, CTRL, 32'h2);
        peer.send(8'h9e, 1'b1);
        repeat (2) @(posedge clk_sys);
        rdc("ir_rx", A5, 32'h9e);
        apb(1'b1, A5, 32'hc3);
        wait_tx(1);
        check("ir_tx", peer.got[0], 32'h1c3);
        complete_run();
    end
endmodule // shadow_data_port_tb
